// ### dv/acc_checksum_asserts.sv
// assertions on the checksum block ports: config, rx flags, tx handshake
// assumes acc_checksum as top, one clock, sync active-high reset
`timescale 1ns/1ps
module acc_checksum_asserts (
   input wire logic       mclk_i,
   input wire logic       reset_i,
   input wire logic       cfg_wr_i,
   input wire logic [7:0] cfg_data_i,
   input wire logic       cks_en_o,
   input wire logic       cfg_mode_o,
   input wire logic       rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic       cmd_valid_o,
   input wire logic [7:0] cmd_data_o,
   input wire logic       cmd_end_o,
   input wire logic       cmd_good_o,
   input wire logic       cmd_drop_o,
   input wire logic       rsp_valid_i,
   input wire logic [7:0] rsp_data_i,
   input wire logic       rsp_last_i,
   input wire logic       rsp_ready_o,
   input wire logic       tx_valid_o,
   input wire logic [7:0] tx_data_o,
   input wire logic       tx_ready_i
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   wire logic cr_in = rx_valid_i && rx_data_i == acc_pkg::CHAR_CR;
   a_cmd_copy: assert property (rx_valid_i |=> cmd_valid_o && cmd_data_o == $past(rx_data_i))
      else $error("command copy wrong");
   a_end_cr: assert property (cr_in |=> cmd_end_o)
      else $error("no end flag after carriage return");
   a_good_xor: assert property (cmd_end_o |-> cmd_good_o != cmd_drop_o)
      else $error("good and drop not exclusive");
   a_off_good: assert property (cr_in && !cks_en_o |=> cmd_good_o)
      else $error("command refused with checksum off");
   a_cfg_en: assert property (cfg_wr_i && cfg_mode_o ##1 !cfg_wr_i |=>
      cks_en_o == $past(cfg_data_i[acc_pkg::CKS_EN_BIT], 2)) else $error("enable not from bit 6");
   // mode output lags the internal mode by one edge, so two quiet samples are needed
   a_cfg_lock: assert property (!cfg_mode_o ##1 !cfg_mode_o |=> $stable(cks_en_o))
      else $error("enable changed outside config mode");
   a_rsp_pass: assert property (rsp_valid_i && rsp_ready_o |=>
      tx_valid_o && tx_data_o == $past(rsp_data_i)) else $error("taken response char lost");
   a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("tx character not held");
   a_ready_low: assert property (rsp_valid_i && rsp_ready_o && rsp_last_i |=> !rsp_ready_o [*2])
      else $error("response taken before trailer sent");
   cover property (cmd_drop_o);
   cover property (cmd_good_o && cks_en_o);
   cover property (tx_valid_o && !tx_ready_i);
endmodule : acc_checksum_asserts
bind acc_checksum acc_checksum_asserts u_chk (.*);

// ### dv/acc_host_model.sv
// host model: sends command strings and collects response characters
// assumes the block samples on rising edges; this model drives on falling edges
`timescale 1ns/1ps
module acc_host_model (
   input  wire logic       mclk_i,
   input  wire logic       stall_i,
   output logic            rx_valid_o,
   output logic      [7:0] rx_data_o,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o
);
   logic [7:0] got[$];
   int         cyc = 0;
   initial begin
      rx_valid_o = 1'b0;
      rx_data_o  = 8'h00;
      tx_ready_o = 1'b1;
   end
   // stalls every third cycle so the block has to hold its output
   always @(negedge mclk_i) begin
      cyc++;
      tx_ready_o <= !(stall_i && cyc % 3 == 0);
   end
   always @(posedge mclk_i) begin
      if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
   end
   // add_cks appends the sum as two hex digits, as a compliant host must
   task automatic send(input string s, input bit add_cks);
      logic [7:0] sum;
      string      t;
      sum = 8'h00;
      for (int i = 0; i < s.len(); i++) sum += s[i];
      t = add_cks ? {s, $sformatf("%02X", sum), "\r"} : {s, "\r"};
      for (int i = 0; i < t.len(); i++) begin
         @(negedge mclk_i);
         rx_valid_o = 1'b1;
         rx_data_o  = t[i];
      end
      @(negedge mclk_i);
      rx_valid_o = 1'b0;
      rx_data_o  = ~rx_data_o;
   endtask : send
endmodule : acc_host_model

// ### dv/ascii_command_checksum_tb.sv
// testbench for the checksum block: config, command checking, response trailer
// assumes acc_host_model as the far side; inputs change on falling edges
`timescale 1ns/1ps
module ascii_command_checksum_tb;
   logic mclk_i = 0, reset_i = 1, init_strap_n_i = 0, cfg_wr_i = 0, stall = 0;
   logic rsp_valid_i = 0, rsp_last_i = 0, rx_valid_i, tx_valid_o, tx_ready_i, cks_en_o;
   logic cfg_mode_o, cmd_valid_o, cmd_end_o, cmd_good_o, cmd_drop_o, rsp_ready_o;
   logic [7:0] cfg_data_i = 8'h00, rsp_data_i = 8'h00, rx_data_i, cmd_data_o, tx_data_o;
   int n_mismatch = 0, num_checks = 0, cyc = 0;
   initial forever #2 mclk_i = ~mclk_i;
   acc_checksum u_dut (.*);
   acc_host_model u_host (.mclk_i, .stall_i(stall), .rx_valid_o(rx_valid_i),
      .rx_data_o(rx_data_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
      .tx_ready_o(tx_ready_i));
   task automatic final_report;
      if (n_mismatch == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         final_report();
      end
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic do_reset(input logic strap);
      @(negedge mclk_i);
      reset_i = 1'b1;
      init_strap_n_i = strap;
      repeat (8) @(negedge mclk_i);
      reset_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk("cfg_mode", cfg_mode_o, !strap);
   endtask : do_reset
   task automatic t_cfg(input logic [7:0] d, input logic exp);
      cfg_wr_i = 1'b1;
      cfg_data_i = d;
      @(negedge mclk_i);
      cfg_wr_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      chk("cks_en", cks_en_o, exp);
   endtask : t_cfg
   task automatic t_rx(input string s, input bit add, input logic good);
      u_host.send(s, add);
      chk("cmd_valid", cmd_valid_o, 1'b1);
      chk("cmd_data", cmd_data_o, acc_pkg::CHAR_CR);
      chk("cmd_end", cmd_end_o, 1'b1);
      chk("cmd_good", cmd_good_o, good);
      chk("cmd_drop", cmd_drop_o, !good);
   endtask : t_rx
   task automatic t_tx(input string s, input string exp);
      u_host.got.delete();
      for (int i = 0; i < s.len(); i++) begin
         rsp_valid_i = 1'b1;
         rsp_data_i = s[i];
         rsp_last_i = (i == s.len() - 1);
         while (!rsp_ready_o) @(negedge mclk_i);
         @(negedge mclk_i);
      end
      rsp_valid_i = 1'b0;
      rsp_last_i = 1'b0;
      rsp_data_i = ~rsp_data_i;
      for (int k = 0; k < 60 && u_host.got.size() < exp.len(); k++) @(negedge mclk_i);
      repeat (4) @(negedge mclk_i);
      chk("tx_len", 8'(u_host.got.size()), 8'(exp.len()));
      chk("rsp_ready", rsp_ready_o, 1'b1);
      foreach (u_host.got[i]) chk("tx_char", u_host.got[i], exp[i]);
   endtask : t_tx
   initial begin
      do_reset(1'b0);
      t_cfg(8'hBF, 1'b0);
      t_cfg(8'h40, 1'b1);
      t_rx("$07S1RH", 1, 1'b1);
      t_rx("#05S1", 1, 1'b1);
      t_rx("$07S1RHA8", 0, 1'b0);
      t_rx("$07S1RH", 0, 1'b0);
      t_rx("", 0, 1'b0);
      t_rx("$07S1RHa9", 0, 1'b1);
      stall = 1'b1;
      t_tx("!07+2.0500", "!07+2.0500D8\r");
      stall = 1'b0;
      t_cfg(8'h00, 1'b0);
      t_rx("$07S1RHA8", 0, 1'b1);
      t_tx("!07+2.0500", "!07+2.0500\r");
      do_reset(1'b1);
      t_cfg(8'h40, 1'b0);
      final_report();
   end
endmodule : ascii_command_checksum_tb

// ### rtl/acc_checksum.sv
// checksum checker for received commands and generator for responses
// assumes byte streams, rx with valid only and rsp/tx with valid/ready; rx command ends with a carriage return,
// tx response text is given without its carriage return and ends with rsp_last_i
`timescale 1ns/1ps
// Summary of operation
// [RQ1] with checksumming on, commands and responses carry two extra checksum characters.
// [RQ2] checksumming turns on when bit 6 of the format/checksum configuration byte is 1.
// [RQ3] a configuration byte written with that bit at 0 turns checksumming off.
// [RQ4] the configuration is taken only while the init strap was low at the restart.
// [RQ5] the checksum is two ascii hex characters just before the carriage return.
// [RQ6] the checksum is the sum of all preceding character codes modulo 256.
// [RQ7] a command with a missing or wrong checksum is dropped and gets no reply.
// [RQ8] the host uses the same setting and appends a valid checksum to each command.
// [RQ9] the response checksum covers the whole text from its leading delimiter onward.
// [RQ10] checksum digits go out most significant first with upper-case letters.
module acc_checksum (
   input  wire logic       mclk_i,
   input  wire logic       reset_i,
   input  wire logic       init_strap_n_i,
   input  wire logic       cfg_wr_i,
   input  wire logic [7:0] cfg_data_i,
   output logic            cks_en_o,
   output logic            cfg_mode_o,
   input  wire logic       rx_valid_i,
   input  wire logic [7:0] rx_data_i,
   output logic            cmd_valid_o,
   output logic [7:0]      cmd_data_o,
   output logic            cmd_end_o,
   output logic            cmd_good_o,
   output logic            cmd_drop_o,
   input  wire logic       rsp_valid_i,
   input  wire logic [7:0] rsp_data_i,
   input  wire logic       rsp_last_i,
   output logic            rsp_ready_o,
   output logic            tx_valid_o,
   output logic [7:0]      tx_data_o,
   input  wire logic       tx_ready_i
);
   logic [7:0]          cfg_r;
   logic                cfg_mode_r;
   logic                strap_done_r;
   logic [7:0]          rx_sum_r;
   logic [7:0]          rx_p1_r;
   logic [7:0]          rx_p2_r;
   logic [1:0]          rx_cnt_r;
   logic [7:0]          tx_sum_r;
   logic [7:0]          tx_sum_nxt;
   acc_pkg::acc_tx_state_e tx_st_r;
   logic [7:0]          hex_chr;
   logic [3:0]          hi_val;
   logic [3:0]          lo_val;
   logic                hi_ok;
   logic                lo_ok;
   logic [3:0]          tx_nib;
   logic [7:0]          sum_back2;
   logic                cks_match;
   logic                take_rsp;
   logic                tx_free;

   // strap is sampled once after reset release, never under reset itself
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         strap_done_r <= 1'b0;
         cfg_mode_r   <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         cfg_mode_r   <= !init_strap_n_i; // RQ4
      end
   end

   // the configuration survives reset only as its reset value; real storage is nonvolatile
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cfg_r <= acc_pkg::CFG_RESET;
      end else if (cfg_wr_i && cfg_mode_r) begin
         cfg_r <= cfg_data_i; // RQ4
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cks_en_o   <= 1'b0;
         cfg_mode_o <= 1'b0;
      end else begin
         cks_en_o   <= cfg_r[acc_pkg::CKS_EN_BIT]; // RQ2 RQ3
         cfg_mode_o <= cfg_mode_r;
      end
   end

   // receive: keep a running sum and the last two characters; at the carriage return
   // the last two are the checksum and the sum before them is the reference
   acc_hex u_hex_hi (
      .nib_i (tx_nib),
      .chr_o (hex_chr),
      .chr_i (rx_p2_r),
      .val_o (hi_val),
      .ok_o  (hi_ok)
   );
   acc_hex u_hex_lo (
      .nib_i (4'h0),
      .chr_o (),
      .chr_i (rx_p1_r),
      .val_o (lo_val),
      .ok_o  (lo_ok)
   );

   assign sum_back2 = 8'(rx_sum_r - rx_p1_r - rx_p2_r); // RQ6
   assign cks_match = (rx_cnt_r == 2'd2) && hi_ok && lo_ok
                      && ({hi_val, lo_val} == sum_back2); // RQ5 RQ7

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rx_sum_r <= acc_pkg::SUM_RESET;
         rx_p1_r  <= 8'h00;
         rx_p2_r  <= 8'h00;
         rx_cnt_r <= 2'd0;
      end else if (rx_valid_i) begin
         if (rx_data_i == acc_pkg::CHAR_CR) begin
            rx_sum_r <= acc_pkg::SUM_RESET;
            rx_cnt_r <= 2'd0;
         end else begin
            rx_sum_r <= 8'(rx_sum_r + rx_data_i); // RQ6
            rx_p2_r  <= rx_p1_r;
            rx_p1_r  <= rx_data_i;
            if (rx_cnt_r != 2'd2) begin
               rx_cnt_r <= 2'(rx_cnt_r + 2'd1);
            end
         end
      end
   end

   // command characters pass with one cycle of delay; the verdict rides on the end flag
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cmd_valid_o <= 1'b0;
         cmd_data_o  <= 8'h00;
         cmd_end_o   <= 1'b0;
         cmd_good_o  <= 1'b0;
         cmd_drop_o  <= 1'b0;
      end else begin
         cmd_valid_o <= rx_valid_i;
         cmd_data_o  <= rx_data_i;
         cmd_end_o   <= rx_valid_i && (rx_data_i == acc_pkg::CHAR_CR);
         cmd_good_o  <= rx_valid_i && (rx_data_i == acc_pkg::CHAR_CR)
                        && (!cks_en_o || cks_match); // RQ1 RQ7
         cmd_drop_o  <= rx_valid_i && (rx_data_i == acc_pkg::CHAR_CR)
                        && cks_en_o && !cks_match; // RQ7
      end
   end

   // transmit: text passes through, then the two digits if enabled, then the carriage return.
   // ready is registered, so it is raised only when the output register is sure to be empty
   // at the next edge: one idle cycle per text character, traded for having no skid buffer
   assign tx_free    = !tx_valid_o || tx_ready_i;
   assign take_rsp   = rsp_valid_i && rsp_ready_o;
   assign tx_sum_nxt = 8'(tx_sum_r + rsp_data_i); // RQ9
   assign tx_nib     = (tx_st_r == acc_pkg::ACC_TX_HI) ? tx_sum_r[7:4] : tx_sum_r[3:0]; // RQ10

   // ready high implies an empty output register and the idle state, so a taken character
   // always has a place to go even when the host stalls
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rsp_ready_o <= 1'b0;
      end else begin
         rsp_ready_o <= tx_free && (tx_st_r == acc_pkg::ACC_TX_IDLE) && !take_rsp;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         tx_st_r <= acc_pkg::ACC_TX_IDLE;
      end else if (tx_free) begin
         case (tx_st_r)
            acc_pkg::ACC_TX_IDLE: begin
               if (take_rsp && rsp_last_i) begin
                  tx_st_r <= cks_en_o ? acc_pkg::ACC_TX_HI : acc_pkg::ACC_TX_CR; // RQ1
               end
            end
            acc_pkg::ACC_TX_HI: begin
               tx_st_r <= acc_pkg::ACC_TX_LO;
            end
            acc_pkg::ACC_TX_LO: begin
               tx_st_r <= acc_pkg::ACC_TX_CR;
            end
            acc_pkg::ACC_TX_CR: begin
               tx_st_r <= acc_pkg::ACC_TX_IDLE;
            end
            default: begin
               tx_st_r <= acc_pkg::ACC_TX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         tx_sum_r <= acc_pkg::SUM_RESET;
      end else if (take_rsp) begin
         tx_sum_r <= tx_sum_nxt; // RQ9
      end else if (tx_free && (tx_st_r == acc_pkg::ACC_TX_CR)) begin
         tx_sum_r <= acc_pkg::SUM_RESET;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         tx_valid_o <= 1'b0;
         tx_data_o  <= 8'h00;
      end else if (tx_free) begin
         tx_valid_o <= 1'b0;
         case (tx_st_r)
            acc_pkg::ACC_TX_IDLE: begin
               if (take_rsp) begin
                  tx_valid_o <= 1'b1;
                  tx_data_o  <= rsp_data_i;
               end
            end
            acc_pkg::ACC_TX_HI: begin
               tx_valid_o <= 1'b1;
               tx_data_o  <= hex_chr; // RQ5 RQ10
            end
            acc_pkg::ACC_TX_LO: begin
               tx_valid_o <= 1'b1;
               tx_data_o  <= hex_chr; // RQ5
            end
            acc_pkg::ACC_TX_CR: begin
               tx_valid_o <= 1'b1;
               tx_data_o  <= acc_pkg::CHAR_CR;
            end
            default: begin
               tx_valid_o <= 1'b0;
            end
         endcase
      end
   end
endmodule : acc_checksum

// ### rtl/acc_hex.sv
// ascii hex digit helpers: nibble to upper-case digit, digit to nibble
// assumes nothing beyond the package; purely combinational
`timescale 1ns/1ps
module acc_hex (
   input  wire logic [3:0] nib_i,
   output logic      [7:0] chr_o,
   input  wire logic [7:0] chr_i,
   output logic      [3:0] val_o,
   output logic            ok_o
);
   always_comb begin
      if (nib_i < acc_pkg::HEX_TEN) begin
         chr_o = acc_pkg::ASCII_ZERO + {4'h0, nib_i};
      end else begin
         chr_o = acc_pkg::ASCII_UPPER_A + {4'h0, nib_i - acc_pkg::HEX_TEN}; // RQ10
      end
   end

   // lower-case digits from the host are accepted too
   always_comb begin
      ok_o  = 1'b1;
      val_o = 4'h0;
      if (chr_i >= acc_pkg::ASCII_ZERO && chr_i <= 8'h39) begin
         val_o = chr_i[3:0];
      end else if (chr_i >= acc_pkg::ASCII_UPPER_A && chr_i <= 8'h46) begin
         val_o = 4'(chr_i - acc_pkg::ASCII_UPPER_A + 8'h0A);
      end else if (chr_i >= acc_pkg::ASCII_LOWER_A && chr_i <= 8'h66) begin
         val_o = 4'(chr_i - acc_pkg::ASCII_LOWER_A + 8'h0A);
      end else begin
         ok_o = 1'b0;
      end
   end
endmodule : acc_hex

// ### rtl/acc_pkg.sv
// package for the ascii command checksum block: characters, config bits, states
// assumes a byte-wide character stream on one clock
package acc_pkg;
   localparam logic [7:0] CHAR_CR       = 8'h0D;
   localparam int         CKS_EN_BIT    = 6;
   localparam logic [7:0] CFG_RESET     = 8'h00;
   localparam logic [7:0] SUM_RESET     = 8'h00;
   localparam logic [3:0] HEX_TEN       = 4'hA;
   localparam logic [7:0] ASCII_ZERO    = 8'h30;
   localparam logic [7:0] ASCII_UPPER_A = 8'h41;
   localparam logic [7:0] ASCII_LOWER_A = 8'h61;

   typedef enum logic [3:0] {
      ACC_TX_IDLE = 4'h1,
      ACC_TX_HI   = 4'h2,
      ACC_TX_LO   = 4'h4,
      ACC_TX_CR   = 4'h8
   } acc_tx_state_e;
endpackage : acc_pkg
